/* File: pkg/pfm_regs.svh */
// Constants for the port pin function multiplexer.
// Assumes inclusion by bare name; definitions only.
`ifndef PFM_REGS_SVH
`define PFM_REGS_SVH

// ****************************************************************
// Pin indices inside the six-pin vectors
// ****************************************************************
`define PFM_PIN_COUNT 6
`define PFM_IDX_PA0 0
`define PFM_IDX_PA3 1
`define PFM_IDX_PB4 2
`define PFM_IDX_PB5 3
`define PFM_IDX_PB6 4
`define PFM_IDX_PB7 5

// ****************************************************************
// Digital input enable bit positions
// ****************************************************************
`define PFM_PA_DIER_PIN0 0
`define PFM_PA_DIER_PIN3 3
`define PFM_PB_DIER_PIN4 4
`define PFM_PB_DIER_PIN5 5
`define PFM_PB_DIER_PIN6 6
`define PFM_PB_DIER_PIN7 7

// ****************************************************************
// Which pins carry which output sources
// ****************************************************************
`define PFM_TMR_MASK 6'h3E
`define PFM_CMP_MASK 6'h01
`define PFM_PWMG_MASK 6'h3F
// Input path kept alive without enable (interrupt line pin)
`define PFM_IN_KEEP_MASK 6'h01

// ****************************************************************
// Reset values
// ****************************************************************
`define PFM_RST_PINS 6'h00

`endif

/* File: pkg/pfm_pkg.sv */
// Types for the port pin function multiplexer.
// Assumes no other package.
package pfm_pkg;

    // ****************************************************************
    // Pin function and interrupt edge selections
    // ****************************************************************
    typedef enum logic [2:0]
    {
        PFM_GPIO,
        PFM_TMR_PWM,
        PFM_PWMG,
        PFM_CMP_OUT,
        PFM_ANALOG
    } pfm_func_t;

    typedef enum logic [1:0]
    {
        PFM_EDGE_BOTH,
        PFM_EDGE_RISE,
        PFM_EDGE_FALL
    } pfm_edge_t;

endpackage

/* File: logic/pfm_port_mux.sv */
// Pin logic for port A pins 0, 3 and port B pins 4 to 7.
// Assumes pad inputs synchronous to i_clock and control bits held
// by software-visible registers outside this block.
//
// Functional notes
// - Each pin is input or two-state output, pull-high set per pin.
// - Port A dier bit 3 clear kills pin 3 input and its wake-up.
// - Port A dier bit 0 clear blocks wake-up from pin 0 toggles.
// - Port B dier bit 4 clear kills pin 4 input and its wake-up.
// - Port B dier bits 5-7 clear kill those inputs and wake-ups.
// - Port A pin 0 is interrupt line zero, edge chosen by setting.
// - Port B pin 5 is alternate source for line zero, same edges.
// - Port A pin 3: ADC 8, comparator minus 0, timer2, PWM gen 3, key 0.
// - Port A pin 0: ADC 10, comparator out, PWM gen 1, key 4, cap 1.
// - Port B pin 6: ADC 6, comparator minus 4, timer3, PWM gen 2.
// - Port B pin 7: ADC 7, comparator minus 5, timer3, PWM gen 2.
`timescale 1ns/100ps
`include "pfm_regs.svh"

module pfm_port_mux #(
    parameter int PINS = `PFM_PIN_COUNT
)(
    input wire logic i_clock,
    input wire logic i_resetn,
    input wire logic [PINS-1:0] i_pad_in,
    output logic [PINS-1:0] o_pad_out,
    output logic [PINS-1:0] o_pad_oe,
    output logic [PINS-1:0] o_pull_en,
    input wire logic [PINS-1:0] i_dir_out,
    input wire logic [PINS-1:0] i_data_out,
    input wire logic [PINS-1:0] i_pull_high,
    input wire logic [7:0] i_porta_dier,
    input wire logic [7:0] i_portb_dier,
    input wire pfm_pkg::pfm_func_t i_porta_pin0_func,
    input wire pfm_pkg::pfm_func_t i_porta_pin3_func,
    input wire pfm_pkg::pfm_func_t i_portb_pin4_func,
    input wire pfm_pkg::pfm_func_t i_portb_pin5_func,
    input wire pfm_pkg::pfm_func_t i_portb_pin6_func,
    input wire pfm_pkg::pfm_func_t i_portb_pin7_func,
    input wire logic i_timer_two_pwm_out,
    input wire logic i_timer_three_pwm_out,
    input wire logic i_pwm_gen_first_out,
    input wire logic i_pwm_gen_second_out,
    input wire logic i_pwm_gen_third_out,
    input wire logic i_comparator_out,
    input wire logic i_irq0_use_alt,
    input wire pfm_pkg::pfm_edge_t i_irq0_edge,
    output logic [PINS-1:0] o_pin_digital,
    output logic [PINS-1:0] o_analog_sel,
    output logic o_ext_irq_line_zero,
    output logic o_wake_toggle
);

    // ****************************************************************
    // Per-pin tables
    // ****************************************************************
    pfm_pkg::pfm_func_t func [PINS];
    logic [PINS-1:0] tmr_src;
    logic [PINS-1:0] pwmg_src;
    logic [PINS-1:0] dier;
    logic [PINS-1:0] in_en;
    logic [PINS-1:0] wake_en;
    logic [PINS-1:0] next_out;
    logic [PINS-1:0] next_oe;
    logic [PINS-1:0] pad_q;
    logic [PINS-1:0] pad_prev;

    // Pins that own each output source; the others refuse it
    localparam logic [5:0] TMR_PINS = `PFM_TMR_MASK;
    localparam logic [5:0] PWMG_PINS = `PFM_PWMG_MASK;
    localparam logic [5:0] CMP_PINS = `PFM_CMP_MASK;
    localparam logic [5:0] KEEP_PINS = `PFM_IN_KEEP_MASK;

    assign func[`PFM_IDX_PA0] = i_porta_pin0_func;
    assign func[`PFM_IDX_PA3] = i_porta_pin3_func;
    assign func[`PFM_IDX_PB4] = i_portb_pin4_func;
    assign func[`PFM_IDX_PB5] = i_portb_pin5_func;
    assign func[`PFM_IDX_PB6] = i_portb_pin6_func;
    assign func[`PFM_IDX_PB7] = i_portb_pin7_func;

    // Timer PWM wiring per pin, pin 0 of port A has none
    assign tmr_src[`PFM_IDX_PA0] = 1'b0;
    assign tmr_src[`PFM_IDX_PA3] = i_timer_two_pwm_out;
    assign tmr_src[`PFM_IDX_PB4] = i_timer_two_pwm_out;
    assign tmr_src[`PFM_IDX_PB5] = i_timer_three_pwm_out;
    assign tmr_src[`PFM_IDX_PB6] = i_timer_three_pwm_out;
    assign tmr_src[`PFM_IDX_PB7] = i_timer_three_pwm_out;

    assign pwmg_src[`PFM_IDX_PA0] = i_pwm_gen_first_out;
    assign pwmg_src[`PFM_IDX_PA3] = i_pwm_gen_third_out;
    assign pwmg_src[`PFM_IDX_PB4] = i_pwm_gen_first_out;
    assign pwmg_src[`PFM_IDX_PB5] = i_pwm_gen_first_out;
    assign pwmg_src[`PFM_IDX_PB6] = i_pwm_gen_second_out;
    assign pwmg_src[`PFM_IDX_PB7] = i_pwm_gen_second_out;

    assign dier[`PFM_IDX_PA0] = i_porta_dier[`PFM_PA_DIER_PIN0];
    assign dier[`PFM_IDX_PA3] = i_porta_dier[`PFM_PA_DIER_PIN3];
    assign dier[`PFM_IDX_PB4] = i_portb_dier[`PFM_PB_DIER_PIN4];
    assign dier[`PFM_IDX_PB5] = i_portb_dier[`PFM_PB_DIER_PIN5];
    assign dier[`PFM_IDX_PB6] = i_portb_dier[`PFM_PB_DIER_PIN6];
    assign dier[`PFM_IDX_PB7] = i_portb_dier[`PFM_PB_DIER_PIN7];

    // ****************************************************************
    // Output mux, one source per pin
    // ****************************************************************
    genvar g;
    generate
        for (g = 0; g < PINS; g = g + 1)
        begin : g_pin
            logic drv_out;
            logic drv_oe;

            // Analog use (ADC, comparator input, touch, capacitor)
            // floats the driver and blocks the input to stop leakage
            always_comb
            begin
                drv_out = 1'b0;
                drv_oe = 1'b0;
                case (func[g])
                    pfm_pkg::PFM_GPIO:
                    begin
                        drv_out = i_data_out[g];
                        drv_oe = i_dir_out[g];
                    end
                    pfm_pkg::PFM_TMR_PWM:
                    begin
                        drv_out = tmr_src[g];
                        drv_oe = TMR_PINS[g];
                    end
                    pfm_pkg::PFM_PWMG:
                    begin
                        drv_out = pwmg_src[g];
                        drv_oe = PWMG_PINS[g];
                    end
                    pfm_pkg::PFM_CMP_OUT:
                    begin
                        drv_out = i_comparator_out;
                        drv_oe = CMP_PINS[g];
                    end
                    default:
                    begin
                        drv_out = 1'b0;
                        drv_oe = 1'b0;
                    end
                endcase
            end

            assign next_out[g] = drv_out;
            assign next_oe[g] = drv_oe;

            // Pin 0 of port A keeps its input for the interrupt line
            assign in_en[g] = (func[g] != pfm_pkg::PFM_ANALOG)
                && (dier[g] || KEEP_PINS[g]);
            assign wake_en[g] = dier[g] && in_en[g];

            a_gpio_drive: assert property (@(posedge i_clock)
                disable iff (!i_resetn) (func[g] == pfm_pkg::PFM_GPIO)
                |=> o_pad_oe[g] == $past(i_dir_out[g])
                && o_pad_out[g] == $past(i_data_out[g] & i_dir_out[g]))
                else $error("gpio pin does not follow direction or data");
            a_input_gate: assert property (@(posedge i_clock)
                disable iff (!i_resetn) !in_en[g] |=> !o_pin_digital[g])
                else $error("disabled input still reaches core");
            a_analog_float: assert property (@(posedge i_clock)
                disable iff (!i_resetn)
                (func[g] == pfm_pkg::PFM_ANALOG) |=> !o_pad_oe[g]
                && !o_pull_en[g])
                else $error("analog pin still driven or pulled");
        end
    endgenerate

    // ****************************************************************
    // Registered pad drive, pull and analog select
    // ****************************************************************
    always_ff @(posedge i_clock)
    begin
        if (!i_resetn)
        begin
            o_pad_out <= `PFM_RST_PINS;
            o_pad_oe <= `PFM_RST_PINS;
        end
        else
        begin
            o_pad_out <= next_out & next_oe;
            o_pad_oe <= next_oe;
        end
    end

    always_ff @(posedge i_clock)
    begin
        if (!i_resetn)
        begin
            o_pull_en <= `PFM_RST_PINS;
            o_analog_sel <= `PFM_RST_PINS;
        end
        else
        begin
            for (int k = 0; k < PINS; k++)
            begin
                o_analog_sel[k] <= func[k] == pfm_pkg::PFM_ANALOG;
                o_pull_en[k] <= i_pull_high[k]
                    && func[k] != pfm_pkg::PFM_ANALOG;
            end
        end
    end

    // ****************************************************************
    // Input path and wake-up
    // ****************************************************************
    always_ff @(posedge i_clock)
    begin
        if (!i_resetn)
        begin
            pad_q <= `PFM_RST_PINS;
            pad_prev <= `PFM_RST_PINS;
            o_pin_digital <= `PFM_RST_PINS;
        end
        else
        begin
            pad_q <= i_pad_in;
            pad_prev <= pad_q;
            o_pin_digital <= pad_q & in_en;
        end
    end

    // Toggle seen only on pins whose enable bit is set
    always_ff @(posedge i_clock)
    begin
        if (!i_resetn)
            o_wake_toggle <= 1'b0;
        else
            o_wake_toggle <= |((pad_q ^ pad_prev) & wake_en);
    end

    a_wake_block: assert property (@(posedge i_clock) disable iff (!i_resetn)
        (wake_en == 6'h00) |=> !o_wake_toggle)
        else $error("wake-up raised with all wake enables off");

    // ****************************************************************
    // External interrupt line zero
    // ****************************************************************
    logic irq_in;
    logic irq_prev;
    logic next_irq;

    assign irq_in = i_irq0_use_alt ? o_pin_digital[`PFM_IDX_PB5]
        : o_pin_digital[`PFM_IDX_PA0];

    always_comb
    begin
        next_irq = 1'b0;
        case (i_irq0_edge)
            pfm_pkg::PFM_EDGE_BOTH: next_irq = irq_in ^ irq_prev;
            pfm_pkg::PFM_EDGE_RISE: next_irq = irq_in & !irq_prev;
            pfm_pkg::PFM_EDGE_FALL: next_irq = !irq_in & irq_prev;
            default: next_irq = 1'b0;
        endcase
    end

    // Switching source can look like an edge; software should
    // change the source with the line masked.
    always_ff @(posedge i_clock)
    begin
        if (!i_resetn)
        begin
            irq_prev <= 1'b0;
            o_ext_irq_line_zero <= 1'b0;
        end
        else
        begin
            irq_prev <= irq_in;
            o_ext_irq_line_zero <= next_irq;
        end
    end

    a_irq_rise: assert property (@(posedge i_clock) disable iff (!i_resetn)
        (irq_in && !irq_prev && i_irq0_edge != pfm_pkg::PFM_EDGE_FALL)
        |=> o_ext_irq_line_zero)
        else $error("rising edge not reported on line zero");
    a_irq_fall_only: assert property (@(posedge i_clock)
        disable iff (!i_resetn)
        (irq_in && !irq_prev && i_irq0_edge == pfm_pkg::PFM_EDGE_FALL)
        |=> !o_ext_irq_line_zero)
        else $error("rising edge reported in falling-only mode");
    a_irq_alt_src: assert property (@(posedge i_clock)
        disable iff (!i_resetn)
        (i_irq0_use_alt && $stable(i_irq0_use_alt)
        && $fell(o_pin_digital[`PFM_IDX_PB5])
        && i_irq0_edge == pfm_pkg::PFM_EDGE_BOTH)
        |=> o_ext_irq_line_zero)
        else $error("alternate pin edge lost on line zero");

    // ****************************************************************
    // Source routing checks
    // ****************************************************************
    a_pa3_timer: assert property (@(posedge i_clock) disable iff (!i_resetn)
        (i_porta_pin3_func == pfm_pkg::PFM_TMR_PWM)
        |=> o_pad_oe[`PFM_IDX_PA3]
        && o_pad_out[`PFM_IDX_PA3] == $past(i_timer_two_pwm_out))
        else $error("timer two output not on port A pin 3");
    a_pa0_cmp: assert property (@(posedge i_clock) disable iff (!i_resetn)
        (i_porta_pin0_func == pfm_pkg::PFM_CMP_OUT) |=>
        o_pad_oe[`PFM_IDX_PA0]
        && o_pad_out[`PFM_IDX_PA0] == $past(i_comparator_out))
        else $error("comparator output not on port A pin 0");
    a_pb6_pwmg: assert property (@(posedge i_clock) disable iff (!i_resetn)
        (i_portb_pin6_func == pfm_pkg::PFM_PWMG) |=>
        o_pad_oe[`PFM_IDX_PB6]
        && o_pad_out[`PFM_IDX_PB6] == $past(i_pwm_gen_second_out))
        else $error("second generator output not on port B pin 6");
    a_pb7_timer: assert property (@(posedge i_clock) disable iff (!i_resetn)
        (i_portb_pin7_func == pfm_pkg::PFM_TMR_PWM) |=>
        o_pad_oe[`PFM_IDX_PB7]
        && o_pad_out[`PFM_IDX_PB7] == $past(i_timer_three_pwm_out))
        else $error("timer three output not on port B pin 7");

endmodule

/* File: tb/tb_top.sv */
// Self-checking bench for the port pin function multiplexer.
// Assumes the mux is the only device under test, with settings on ports.
`timescale 1ns/100ps
`include "pfm_regs.svh"

module tb_top;
    // ****************************************************************
    // Stimulus and design hookup
    // ****************************************************************
    logic i_clock = 1'b0;
    logic i_resetn = 1'b0;
    logic [5:0] pad, dir, dat, pul, pout, poe, pen, pdig, asel;
    logic [7:0] pa_dier, pb_dier;
    pfm_pkg::pfm_func_t f [6];
    logic t2, t3, g1, g2, g3, cmp, alt, irq, wake, chk = 1'b0;
    pfm_pkg::pfm_edge_t edg;
    logic [31:0] seed = 32'hDE782073;
    int bad_count = 0;
    int n_compared = 0;

    initial forever #25 i_clock = ~i_clock;

    pfm_port_mux i_pfm_port_mux (.i_clock(i_clock), .i_resetn(i_resetn),
        .i_pad_in(pad), .o_pad_out(pout), .o_pad_oe(poe), .o_pull_en(pen),
        .i_dir_out(dir), .i_data_out(dat), .i_pull_high(pul),
        .i_porta_dier(pa_dier), .i_portb_dier(pb_dier),
        .i_porta_pin0_func(f[0]), .i_porta_pin3_func(f[1]),
        .i_portb_pin4_func(f[2]), .i_portb_pin5_func(f[3]),
        .i_portb_pin6_func(f[4]), .i_portb_pin7_func(f[5]),
        .i_timer_two_pwm_out(t2), .i_timer_three_pwm_out(t3),
        .i_pwm_gen_first_out(g1), .i_pwm_gen_second_out(g2),
        .i_pwm_gen_third_out(g3), .i_comparator_out(cmp),
        .i_irq0_use_alt(alt), .i_irq0_edge(edg), .o_pin_digital(pdig),
        .o_analog_sel(asel), .o_ext_irq_line_zero(irq),
        .o_wake_toggle(wake));

    // ****************************************************************
    // Reference model
    // ****************************************************************
    logic [5:0] next_out, next_oe, an, tm, pg, en, wen;
    logic [5:0] e_out, e_oe, e_pull, e_an, pq, pqp, e_pd, pdp;
    logic e_wake, e_irq, cur, prv;

    always_comb
    begin
        tm = {t3, t3, t3, t2, t2, 1'b0};
        pg = {g2, g2, g1, g1, g3, g1};
        en = {pb_dier[7:4], pa_dier[3], 1'b1};
        wen = {pb_dier[7:4], pa_dier[3], pa_dier[0]};
        for (int i = 0; i < 6; i++)
        begin
            an[i] = (f[i] == pfm_pkg::PFM_ANALOG);
            next_oe[i] = 1'b0;
            next_out[i] = 1'b0;
            case (f[i])
                pfm_pkg::PFM_GPIO:
                begin
                    next_oe[i] = dir[i];
                    next_out[i] = dir[i] & dat[i];
                end
                pfm_pkg::PFM_TMR_PWM:
                begin
                    next_oe[i] = (i != 0);
                    next_out[i] = tm[i];
                end
                pfm_pkg::PFM_PWMG:
                begin
                    next_oe[i] = 1'b1;
                    next_out[i] = pg[i];
                end
                pfm_pkg::PFM_CMP_OUT:
                begin
                    next_oe[i] = (i == 0);
                    next_out[i] = (i == 0) & cmp;
                end
                default: ;
            endcase
        end
        cur = alt ? e_pd[`PFM_IDX_PB5] : e_pd[`PFM_IDX_PA0];
        prv = alt ? pdp[`PFM_IDX_PB5] : pdp[`PFM_IDX_PA0];
    end

    always @(posedge i_clock)
    begin
        if (!i_resetn)
        begin
            {e_out, e_oe, e_pull, e_an, pq, pqp, e_pd, pdp} <= 48'h0;
            {e_wake, e_irq} <= 2'h0;
        end
        else
        begin
            e_out <= next_out;
            e_oe <= next_oe;
            e_pull <= pul & ~an;
            e_an <= an;
            pq <= pad;
            pqp <= pq;
            e_pd <= pq & en & ~an;
            pdp <= e_pd;
            e_wake <= |((pq ^ pqp) & wen & ~an);
            case (edg)
                pfm_pkg::PFM_EDGE_RISE: e_irq <= cur & ~prv;
                pfm_pkg::PFM_EDGE_FALL: e_irq <= ~cur & prv;
                default: e_irq <= cur ^ prv;
            endcase
        end
    end

    // ****************************************************************
    // Checking and closing
    // ****************************************************************
    task automatic check(input string nm, input logic [5:0] seen,
                         input logic [5:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    always @(negedge i_clock)
    begin
        if (chk)
        begin
            check("pad_out", pout, e_out);
            check("pad_oe", poe, e_oe);
            check("pull_en", pen, e_pull);
            check("analog_sel", asel, e_an);
            check("pin_digital", pdig, e_pd);
            check("wake", 6'(wake), 6'(e_wake));
            check("irq", {5'h00, irq}, {5'h00, e_irq});
        end
    end

    task automatic complete_run();
        $display("Compared %0d, mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    // Idle pads first so a change of line select gives no false edge
    task automatic drive_idle();
        {pad, dir, dat, pul} = 24'h0;
        {pa_dier, pb_dier} = 16'hFFFF;
        {t2, t3, g1, g2, g3, cmp} = 6'h00;
        for (int i = 0; i < 6; i++)
            f[i] = pfm_pkg::PFM_GPIO;
    endtask

    task automatic drive_rand();
        logic [31:0] r;
        r = xs();
        {pad, dir, dat, pul} = {r[23:0]};
        r = xs();
        {pa_dier, pb_dier, t2, t3, g1, g2, g3, cmp} = r[21:0];
        r = xs();
        for (int i = 0; i < 6; i++)
            f[i] = pfm_pkg::pfm_func_t'(3'((r >> (5 * i)) % 5));
    endtask

    initial
    begin
        drive_idle();
        alt = 1'b0;
        edg = pfm_pkg::PFM_EDGE_BOTH;
        repeat (2) @(negedge i_clock);
        chk = 1'b1;
        repeat (10) @(negedge i_clock);
        i_resetn = 1'b1;
        $display("Test reset done");
        for (int e = 0; e < 3; e++)
            for (int s = 0; s < 2; s++)
            begin
                @(negedge i_clock);
                drive_idle();
                repeat (6) @(negedge i_clock);
                alt = s[0];
                edg = pfm_pkg::pfm_edge_t'(2'(e));
                repeat (400)
                begin
                    @(negedge i_clock);
                    drive_rand();
                end
                $display("Test edge %0d select %0d done", e, s);
            end
        @(negedge i_clock);
        drive_idle();
        i_resetn = 1'b0;
        repeat (3) @(negedge i_clock);
        i_resetn = 1'b1;
        repeat (300)
        begin
            @(negedge i_clock);
            drive_rand();
        end
        $display("Test second reset done");
        complete_run();
    end

    // Run needs about 2760 cycles; allow 5000
    initial
    begin
        #250000;
        bad_count++;
        complete_run();
    end
endmodule
